// [core/dcr_reg_decode.sv]
// control register group decoder with the main control register
`timescale 1ns/1ps

// Functional notes
// - a control frame holds rw, two device address bits, 111, two channel bits, three select bits and thirteen payload bits, msb first.
// - select 000 slew, 001 main, 010 channel control, 011 boost control, 100 software.
// - the status readback enable bit turns readback on when set and resets to zero.
// - the watchdog enable bit turns the watchdog on when set and is off by default.
// - period select 00 is 5 ms, 01 is 10 ms, 10 is 100 ms, 11 is 200 ms.
// - the global output enable turns on all four outputs and is not mixed with per channel enables.
// - the global boost bit powers the boost converter on all four channels.
// - only frames with data register select 111 reach the control group.
module dcr_reg_decode (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // frame from serial shifter
  input wire logic frame_valid_i,
  input wire logic [23:0] frame_i,
  // decoded selects
  output dcr_pkg::dcr_sel_t sel_o,
  output logic sel_valid_o,
  output dcr_pkg::dcr_fwd_t fwd_o,
  // main register fields
  output dcr_pkg::dcr_main_t main_o,
  output logic [15:0] main_readback_o,
  output logic [31:0] wd_period_cyc_o,
  output logic [3:0] chan_output_enable_o,
  output logic [3:0] chan_boost_power_o
);

  // ==========================================================
  // frame decode
  wire logic is_write;
  wire logic [2:0] data_reg_sel;
  wire logic [2:0] ctrl_reg_sel;
  wire logic ctrl_hit;
  wire logic main_hit;
  dcr_pkg::dcr_sel_t sel_d;

  // frame bits, msb first:
  //   23     rw, low for a write
  //   22:21  device address
  //   20:18  data register select, 111 for the control group
  //   17:16  channel
  //   15:13  control register select
  //   12:0   payload
  // reads and other data register selects never reach the group;
  // they are left to the rest of the interface

  // rw low marks a write
  assign is_write = ~frame_i[dcr_pkg::POS_RW];
  assign data_reg_sel =
    frame_i[dcr_pkg::POS_DREG_HI:dcr_pkg::POS_DREG_LO];
  assign ctrl_reg_sel =
    frame_i[dcr_pkg::POS_CREG_HI:dcr_pkg::POS_CREG_LO];
  // a read aimed at the group is dropped here, so no field moves
  // while the host only asks for status
  assign ctrl_hit = frame_valid_i && is_write &&
    (data_reg_sel == dcr_pkg::DREG_CTRL);

  // the main select is 001 with a zero following; the zero is
  // the host's duty, so it is not checked here
  assign main_hit = ctrl_hit &&
    (ctrl_reg_sel == dcr_pkg::CREG_MAIN);

  function automatic dcr_pkg::dcr_sel_t sel_decode(input logic [2:0] c);
    case (c)
      dcr_pkg::CREG_SLEW: sel_decode = dcr_pkg::DCR_SEL_SLEW;
      dcr_pkg::CREG_MAIN: sel_decode = dcr_pkg::DCR_SEL_MAIN;
      dcr_pkg::CREG_CHAN: sel_decode = dcr_pkg::DCR_SEL_CHAN;
      dcr_pkg::CREG_BOOST: sel_decode = dcr_pkg::DCR_SEL_BOOST;
      dcr_pkg::CREG_SOFT: sel_decode = dcr_pkg::DCR_SEL_SOFT;
      // codes 101..111 name no register; the pulse still fires
      default: sel_decode = dcr_pkg::DCR_SEL_NONE;
    endcase
  endfunction

  assign sel_d = ctrl_hit ? sel_decode(ctrl_reg_sel) :
    dcr_pkg::DCR_SEL_NONE;

  // ==========================================================
  // main register
  dcr_pkg::dcr_main_t main_q;
  dcr_pkg::dcr_main_t main_d;
  dcr_pkg::dcr_main_t main_wr;
  dcr_pkg::dcr_sel_t sel_q;
  logic sel_valid_q;
  dcr_pkg::dcr_fwd_t fwd_q;
  logic [31:0] wd_cyc_q;
  wire logic [31:0] wd_cyc_d;

  // period in clock cycles; the timer itself sits outside
  function automatic logic [31:0] wd_cycles(input logic [1:0] s);
    case (s)
      2'h0: wd_cycles = 32'(dcr_pkg::WD_CYC_0);
      2'h1: wd_cycles = 32'(dcr_pkg::WD_CYC_1);
      2'h2: wd_cycles = 32'(dcr_pkg::WD_CYC_2);
      default: wd_cycles = 32'(dcr_pkg::WD_CYC_3);
    endcase
  endfunction

  // main payload, bit 15 down:
  //   15:12  0010, select code and a zero, host's duty
  //   11     status readback enable
  //   10     watchdog enable
  //   9:8    watchdog period select
  //   7:6    ignored
  //   5      global output enable
  //   4      global boost power
  //   3:0    ignored
  // only defined fields are taken; bits 7, 6 and 3..0 are dropped
  assign main_wr = '{
    status_readback_en: frame_i[dcr_pkg::POS_STAT_RB],
    watchdog_en: frame_i[dcr_pkg::POS_WD_EN],
    timeout_period_sel:
      frame_i[dcr_pkg::POS_WD_HI:dcr_pkg::POS_WD_LO],
    global_output_enable: frame_i[dcr_pkg::POS_GOUT],
    global_boost_power: frame_i[dcr_pkg::POS_GBOOST]
  };
  assign main_d = main_hit ? main_wr : main_q;
  assign wd_cyc_d = wd_cycles(main_d.timeout_period_sel);

  // ==========================================================
  // forwarded frame fields
  // slew, channel, boost and software fields are decoded further
  // on; here only the addressing and the raw payload are kept
  dcr_pkg::dcr_fwd_t fwd_new;
  dcr_pkg::dcr_fwd_t fwd_d;

  assign fwd_new = '{
    device_addr: frame_i[dcr_pkg::POS_DEV_HI:dcr_pkg::POS_DEV_LO],
    channel_sel: frame_i[dcr_pkg::POS_CHAN_HI:dcr_pkg::POS_CHAN_LO],
    payload: frame_i[dcr_pkg::POS_PAY_HI:0]
  };
  // last control frame is held so a late reader still sees it
  assign fwd_d = ctrl_hit ? fwd_new : fwd_q;

  // ==========================================================
  // readback word and per channel fan out
  logic [15:0] readback_q;
  wire logic [15:0] readback_d;
  logic [3:0] chan_oe_q;
  wire logic [3:0] chan_oe_d;
  logic [3:0] chan_bp_q;
  wire logic [3:0] chan_bp_d;

  // fixed top nibble 0010 is or'ed in, fields at their bits;
  // the nibble is not stored, so it cannot drift
  assign readback_d = dcr_pkg::MAIN_RST | {
    4'h0,
    main_d.status_readback_en,
    main_d.watchdog_en,
    main_d.timeout_period_sel,
    2'h0,
    main_d.global_output_enable,
    main_d.global_boost_power,
    4'h0
  };

  // global bits fan out to all four channels; per channel bits
  // live in other registers and the host must not mix them
  assign chan_oe_d = {4{main_d.global_output_enable}};
  assign chan_bp_d = {4{main_d.global_boost_power}};

  // ==========================================================
  // select pulse and forwarded fields
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q <= dcr_pkg::DCR_SEL_NONE;
      sel_valid_q <= 1'b0;
      fwd_q <= '0;
    end else begin
      sel_q <= sel_d;
      sel_valid_q <= ctrl_hit;
      fwd_q <= fwd_d;
    end
  end

  // ==========================================================
  // main register and watchdog period
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_q <= '0;
      wd_cyc_q <= 32'(dcr_pkg::WD_CYC_0);
    end else begin
      main_q <= main_d;
      wd_cyc_q <= wd_cyc_d;
    end
  end

  // ==========================================================
  // registered copies for the outputs
  // kept as flops so no output carries decode glitches
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      readback_q <= dcr_pkg::MAIN_RST;
      chan_oe_q <= '0;
      chan_bp_q <= '0;
    end else begin
      readback_q <= readback_d;
      chan_oe_q <= chan_oe_d;
      chan_bp_q <= chan_bp_d;
    end
  end

  // ==========================================================
  // outputs
  // every output is a flop, never a decode term
  assign main_o = main_q;
  assign sel_o = sel_q;
  assign sel_valid_o = sel_valid_q;
  assign fwd_o = fwd_q;
  assign wd_period_cyc_o = wd_cyc_q;
  assign main_readback_o = readback_q;
  assign chan_output_enable_o = chan_oe_q;
  assign chan_boost_power_o = chan_bp_q;

endmodule

// [core/dcr_pkg.sv]
// package: frame layout, select codes and main register defaults
package dcr_pkg;

  // ==========================================================
  // frame layout
  localparam int FRAME_W = 24;
  localparam int POS_RW = 23;
  localparam int POS_DEV_HI = 22;
  localparam int POS_DEV_LO = 21;
  localparam int POS_DREG_HI = 20;
  localparam int POS_DREG_LO = 18;
  localparam int POS_CHAN_HI = 17;
  localparam int POS_CHAN_LO = 16;
  localparam int POS_CREG_HI = 15;
  localparam int POS_CREG_LO = 13;
  localparam int POS_PAY_HI = 12;
  localparam logic [2:0] DREG_CTRL = 3'h7;

  // ==========================================================
  // control register select codes
  localparam logic [2:0] CREG_SLEW = 3'h0;
  localparam logic [2:0] CREG_MAIN = 3'h1;
  localparam logic [2:0] CREG_CHAN = 3'h2;
  localparam logic [2:0] CREG_BOOST = 3'h3;
  localparam logic [2:0] CREG_SOFT = 3'h4;

  // ==========================================================
  // main register fields
  localparam int POS_STAT_RB = 11;
  localparam int POS_WD_EN = 10;
  localparam int POS_WD_HI = 9;
  localparam int POS_WD_LO = 8;
  localparam int POS_GOUT = 5;
  localparam int POS_GBOOST = 4;
  localparam logic [15:0] MAIN_RST = 16'h2000;

  // ==========================================================
  // watchdog periods in ms, cycles at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int WD_MS_0 = 5;
  localparam int WD_MS_1 = 10;
  localparam int WD_MS_2 = 100;
  localparam int WD_MS_3 = 200;
  localparam longint WD_CYC_0 = longint'(WD_MS_0) * CLK_HZ / 1000;
  localparam longint WD_CYC_1 = longint'(WD_MS_1) * CLK_HZ / 1000;
  localparam longint WD_CYC_2 = longint'(WD_MS_2) * CLK_HZ / 1000;
  localparam longint WD_CYC_3 = longint'(WD_MS_3) * CLK_HZ / 1000;

  typedef enum logic [2:0] {
    DCR_SEL_NONE,
    DCR_SEL_SLEW,
    DCR_SEL_MAIN,
    DCR_SEL_CHAN,
    DCR_SEL_BOOST,
    DCR_SEL_SOFT
  } dcr_sel_t;

  typedef struct packed {
    logic status_readback_en;
    logic watchdog_en;
    logic [1:0] timeout_period_sel;
    logic global_output_enable;
    logic global_boost_power;
  } dcr_main_t;

  typedef struct packed {
    logic [1:0] device_addr;
    logic [1:0] channel_sel;
    logic [12:0] payload;
  } dcr_fwd_t;

endpackage

// [verif/dcr_host_model.sv]
// host model: drives frames into the decoder
`timescale 1ns/1ps
module dcr_host_model (
  // clock
  input wire logic clk_i,
  // frame out
  output logic frame_valid_o = 1'b0,
  output logic [23:0] frame_o = 24'h000000
);
  // released lines show the inverse, never a stale copy
  task automatic send(input logic [23:0] f);
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b1;
    frame_o = f;
    @(posedge clk_i);
    #1;
    frame_valid_o = 1'b0;
    frame_o = ~f;
  endtask
endmodule

// [verif/dcr_reg_decode_assertions.sv]
// checker: decode timing and main register fields
`timescale 1ns/1ps
module dcr_reg_decode_assertions (
  // clock, reset, frame
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic frame_valid_i,
  input wire logic [23:0] frame_i,
  // outputs
  input wire dcr_pkg::dcr_sel_t sel_o,
  input wire logic sel_valid_o,
  input wire dcr_pkg::dcr_fwd_t fwd_o,
  input wire dcr_pkg::dcr_main_t main_o,
  input wire logic [31:0] wd_period_cyc_o,
  input wire logic [3:0] chan_output_enable_o,
  input wire logic [3:0] chan_boost_power_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic hit = frame_valid_i && !frame_i[23] && frame_i[20:18] == 3'h7;
  wire logic mh = hit && frame_i[15:13] == 3'h1;
  wire logic [1:0] t = main_o.timeout_period_sel;
  property p_pulse; hit |=> sel_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse");
  property p_idle; !hit |=> !sel_valid_o && sel_o == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray select");
  property p_code; hit && frame_i[15:13] < 3'h5 |=>
    sel_o == $past(frame_i[15:13]) + 3'h1; endproperty
  a_code: assert property (p_code) else $error("bad select");
  property p_fwd; hit |=>
    fwd_o == $past({frame_i[22:21], frame_i[17:16], frame_i[12:0]}); endproperty
  a_fwd: assert property (p_fwd) else $error("bad forward");
  property p_main; mh |=>
    main_o == $past({frame_i[11:8], frame_i[5:4]}); endproperty
  a_main: assert property (p_main) else $error("bad main");
  property p_hold; !mh |=> $stable(main_o); endproperty
  a_hold: assert property (p_hold) else $error("main moved");
  property p_wd; 1 |-> wd_period_cyc_o == (t[1] ? (t[0] ? 32'h00989680 :
    32'h004C4B40) : (t[0] ? 32'h0007A120 : 32'h0003D090)); endproperty
  a_wd: assert property (p_wd) else $error("bad period");
  property p_out; chan_output_enable_o == {4{main_o[1]}}; endproperty
  a_out: assert property (p_out) else $error("bad outputs");
  property p_bst; chan_boost_power_o == {4{main_o[0]}}; endproperty
  a_bst: assert property (p_bst) else $error("bad boost");
endmodule
bind dcr_reg_decode dcr_reg_decode_assertions i_dcr_reg_decode_assertions (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .frame_valid_i(frame_valid_i),
  .frame_i(frame_i), .sel_o(sel_o), .sel_valid_o(sel_valid_o), .fwd_o(fwd_o),
  .main_o(main_o), .wd_period_cyc_o(wd_period_cyc_o),
  .chan_output_enable_o(chan_output_enable_o),
  .chan_boost_power_o(chan_boost_power_o));

// [verif/test_dcr_reg_decode.sv]
// testbench: frame writes into the control register decoder
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_dcr_reg_decode;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic fv;
  logic [23:0] fr;
  dcr_pkg::dcr_sel_t sel;
  logic sv;
  dcr_pkg::dcr_fwd_t fwd;
  dcr_pkg::dcr_main_t mn;
  logic [31:0] wd;
  logic [3:0] oe;
  logic [3:0] bp;
  logic [15:0] rb;
  int checks = 0;
  int miscompares = 0;
  logic [31:0] tab [4] = '{32'h3D090, 32'h7A120, 32'h4C4B40, 32'h989680};
  dcr_reg_decode i_dcr_reg_decode (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .frame_valid_i(fv), .frame_i(fr), .sel_o(sel), .sel_valid_o(sv),
    .fwd_o(fwd), .main_o(mn), .main_readback_o(rb), .wd_period_cyc_o(wd),
    .chan_output_enable_o(oe), .chan_boost_power_o(bp));
  dcr_host_model i_dcr_host_model (.clk_i(clk_i), .frame_valid_o(fv),
    .frame_o(fr));
  function automatic logic [23:0] mk(logic rw, logic [2:0] dr, cr,
    logic [12:0] p);
    return {rw, 2'h2, dr, 2'h1, cr, p};
  endfunction
  // don't care bits set on purpose, bit 12 kept zero
  task automatic wr_main(input logic [5:0] v);
    i_dcr_host_model.send(mk(0, 7, 1, {1'b0, v[5:2], 2'h3, v[1:0], 4'hF}));
    `CHK(mn, v)
    `CHK(rb, {4'h2, v[5:2], 2'h0, v[1:0], 4'h0})
    `CHK(wd, tab[v[3:2]])
    `CHK(oe, {4{v[1]}})
    `CHK(bp, {4{v[0]}})
  endtask
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #10 clk_i = ~clk_i;
  initial begin
    repeat (2000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    `CHK(mn, 6'h00)
    rst_b_i = 1'b1;
    // outputs only on while boost is on, and off before it
    for (int i = 0; i < 4; i++) wr_main({i[0], i[1], i[1:0], &i[1:0], |i[1:0]});
    wr_main(6'h01);
    wr_main(6'h28);
    for (int r = 0; r < 2; r++) begin
      i_dcr_host_model.send(mk(r == 0, r ? 6 : 7, 1, 13'h1FFF));
      `CHK(sv, 1'b0)
      `CHK(mn, 6'h28)
    end
    for (int c = 0; c < 8; c++) begin
      i_dcr_host_model.send(mk(0, 7, c, 13'(c * 3 + 1)));
      `CHK(sv, 1'b1)
      `CHK(sel, (c < 5) ? 3'(c + 1) : 3'h0)
      `CHK(fwd, {2'h2, 2'h1, 13'(c * 3 + 1)})
    end
    complete_run();
  end
endmodule
